// ==== gamma_nvm_pkg.sv ====
// Constants, types and ECC helpers for the two-bank acquire block
// Summary of operation
// - Target address is six fixed upper bits plus the address strap level.
// - Strap low answers 1110100 only; strap high answers 1110101 only.
// - Bank select low uses store zero, high uses store one.
// - Each bank allows sixteen programming operations per channel, counted per bank.
// - Any bank select change reloads every channel from the new bank.
// - At power-up the bank select level picks the bank loaded.
// - A software acquire loads from the bank currently selected by the pin.
// - General acquire is one pointer byte, bit7 set, bit6 clear, then stop.
// - About 750 us after general acquire all eighteen channels take stored values.
// - Single acquire is one pointer byte, bit7 clear, bit6 set, then stop.
// - About 36 us after single acquire only the addressed channel updates.
// - Pointers 000000 to 010111 acknowledged; data only at 0-15, 010010, 010011.
// - Reads of unused acknowledged pointers return zero.
// - Write-count report is read at pointer 111111.
// - Single acquire sets report to addressed channel's programming count code.
// - General acquire sets report to the highest count code of all channels.
// - Report is read-only and changes only when an acquire completes.
// - Code is zero for 0 or 1 operations, else operations minus one.
// - Single failed bit in a stored word is corrected on load.
// - Two failed bits in a stored word load the default level 1000000000.
// - After bank select change all channels change together after about 750 us.
package gamma_nvm_pkg;
  localparam int CLK_FREQ_MHZ = 125;
  localparam int GEN_ACQ_TIME_US = 750;
  localparam int SNG_ACQ_TIME_US = 36;
  localparam int GEN_ACQ_CYCLES = GEN_ACQ_TIME_US * CLK_FREQ_MHZ;
  localparam int SNG_ACQ_CYCLES = SNG_ACQ_TIME_US * CLK_FREQ_MHZ;
  localparam int WAIT_W = 17;
  localparam int NUM_CHAN = 18;
  localparam int NUM_ENTRY = 2 * NUM_CHAN;
  localparam int IDX_W = 5;
  localparam int LEVEL_W = 10;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam int CODE_W = 4;
  localparam logic [5:0] TARGET_ADDR_HI = 6'h3a;
  localparam logic [5:0] PTR_LAST_GAMMA = 6'h0f;
  localparam logic [5:0] PTR_COMMON_FIRST = 6'h12;
  localparam logic [5:0] PTR_COMMON_SECOND = 6'h13;
  localparam logic [5:0] PTR_ACK_LAST = 6'h17;
  localparam logic [5:0] PTR_WRITE_COUNT = 6'h3f;
  localparam logic [1:0] CMD_GENERAL = 2'h2;
  localparam logic [1:0] CMD_SINGLE = 2'h1;
  localparam logic [9:0] DEFAULT_LEVEL = 10'h200;
  localparam logic [4:0] CNT_MAX = 5'h10;
  localparam logic [4:0] IDX_LAST = 5'h11;
  localparam logic [4:0] IDX_COMMON_FIRST = 5'h10;
  localparam logic [4:0] IDX_COMMON_SECOND = 5'h11;
  localparam logic [5:0] BANK_ONE_BASE = 6'h12;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    B_IDLE = 4'h0,
    B_ADDR = 4'h1,
    B_ADDR_ACK = 4'h2,
    B_PTR = 4'h3,
    B_PTR_ACK = 4'h4,
    B_WDATA = 4'h5,
    B_WDATA_ACK = 4'h6,
    B_RDATA = 4'h7,
    B_RACK = 4'h8
  } bus_state_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_WAIT = 3'h1,
    SEQ_ISSUE = 3'h2,
    SEQ_TAKE = 3'h3,
    SEQ_COMMIT = 3'h4
  } seq_state_t;

  typedef logic [NUM_CHAN-1:0][LEVEL_W-1:0] level_array_t;

  function automatic logic ptr_has_data(input logic [5:0] p);
    return (p <= PTR_LAST_GAMMA) || (p == PTR_COMMON_FIRST) || (p == PTR_COMMON_SECOND);
  endfunction : ptr_has_data

  function automatic logic [4:0] ptr_to_idx(input logic [5:0] p);
    if (p <= PTR_LAST_GAMMA) begin
      return p[4:0];
    end
    return (p == PTR_COMMON_FIRST) ? IDX_COMMON_FIRST : IDX_COMMON_SECOND;
  endfunction : ptr_to_idx

  function automatic logic [3:0] wc_code(input logic [4:0] c);
    return (c <= 5'h01) ? 4'h0 : 4'(c - 5'h01);
  endfunction : wc_code

  // Hamming positions 1..15 with parity at powers of two, overall parity in bit 0
  function automatic logic [15:0] ecc_encode(input logic [9:0] d);
    logic [15:0] w;
    logic [3:0] syn;
    int k;
    w = 16'h0000;
    syn = 4'h0;
    k = 0;
    for (int p = 3; p < 16; p++) begin
      if (((p & (p - 1)) != 0) && (k < 10)) begin
        w[p] = d[k];
        k++;
        if (w[p]) begin
          syn = syn ^ p[3:0];
        end
      end
    end
    w[1] = syn[0];
    w[2] = syn[1];
    w[4] = syn[2];
    w[8] = syn[3];
    w[0] = ^w[15:1];
    return w;
  endfunction : ecc_encode

  function automatic logic [9:0] ecc_decode(input logic [15:0] w);
    logic [15:0] c;
    logic [3:0] syn;
    logic par;
    logic [9:0] d;
    int k;
    syn = 4'h0;
    par = ^w;
    d = 10'h000;
    k = 0;
    for (int p = 1; p < 16; p++) begin
      if (w[p]) begin
        syn = syn ^ p[3:0];
      end
    end
    c = w;
    if (par) begin
      c[syn] = ~c[syn];
    end
    for (int p = 3; p < 16; p++) begin
      if (((p & (p - 1)) != 0) && (k < 10)) begin
        d[k] = c[p];
        k++;
      end
    end
    if (!par && (syn != 4'h0)) begin
      d = DEFAULT_LEVEL;
    end
    return d;
  endfunction : ecc_decode
endpackage : gamma_nvm_pkg

// ==== nv_store.sv ====
// Two-bank nonvolatile word and programming-count store with registered read
module nv_store
  import gamma_nvm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic wr_bank_in,
  input wire logic [IDX_W-1:0] wr_idx_in,
  input wire logic [WORD_W-1:0] wr_word_in,
  input wire logic rd_en_in,
  input wire logic rd_bank_in,
  input wire logic [IDX_W-1:0] rd_idx_in,
  output logic [WORD_W-1:0] rd_word_out,
  output logic [CNT_W-1:0] rd_cnt_out
);
  typedef struct packed {
    logic [NUM_ENTRY-1:0][WORD_W-1:0] word;
    logic [NUM_ENTRY-1:0][CNT_W-1:0] cnt;
    logic [WORD_W-1:0] rd_word;
    logic [CNT_W-1:0] rd_cnt;
  } store_state_t;

  store_state_t st_ff;
  store_state_t nxt_st;
  logic [5:0] wr_addr;
  logic [5:0] rd_addr;

  assign wr_addr = {1'b0, wr_idx_in} + (wr_bank_in ? BANK_ONE_BASE : 6'h00);
  assign rd_addr = {1'b0, rd_idx_in} + (rd_bank_in ? BANK_ONE_BASE : 6'h00);

  always_comb begin
    nxt_st = st_ff;
    for (int e = 0; e < NUM_ENTRY; e++) begin
      // Worn-out words refuse further programming
      if (wr_en_in && (wr_addr == 6'(e)) && (st_ff.cnt[e] != CNT_MAX)) begin
        nxt_st.word[e] = wr_word_in;
        nxt_st.cnt[e] = st_ff.cnt[e] + 5'h01;
      end
    end
    if (rd_en_in) begin
      nxt_st.rd_word = st_ff.word[rd_addr];
      nxt_st.rd_cnt = st_ff.cnt[rd_addr];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else if (ce_in) begin
      st_ff <= nxt_st;
    end
  end

  assign rd_word_out = st_ff.rd_word;
  assign rd_cnt_out = st_ff.rd_cnt;
endmodule : nv_store

// ==== gamma_nvm_bank_acquire.sv ====
// Serial target, bank select and acquire sequencer of the gamma reference store
module gamma_nvm_bank_acquire
  import gamma_nvm_pkg::*;
#(
  parameter logic [WAIT_W-1:0] GEN_ACQ_CYC = WAIT_W'(GEN_ACQ_CYCLES),
  parameter logic [WAIT_W-1:0] SNG_ACQ_CYC = WAIT_W'(SNG_ACQ_CYCLES)
)
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N_OUT,
  input wire logic ADDR_STRAP_PIN_IN,
  input wire logic BANK_SELECT_PIN_IN,
  input wire logic NVM_WR_EN_IN,
  input wire logic NVM_WR_BANK_IN,
  input wire logic [IDX_W-1:0] NVM_WR_IDX_IN,
  input wire logic [WORD_W-1:0] NVM_WR_WORD_IN,
  output level_array_t CHAN_LEVEL_OUT,
  output level_array_t CHAN_PENDING_OUT,
  output logic [CODE_W-1:0] WRITE_COUNT_OUT,
  output logic ACQ_BUSY_OUT
);
  typedef struct packed {
    logic bit_smp;
    logic tgl;
  } link_state_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic strap_s1;
    logic strap_s2;
    logic bank_s1;
    logic bank_s2;
    logic bank_s3;
    bus_state_t bus_st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [5:0] ptr;
    logic [1:0] cmd;
    logic cmd_ok;
    logic second;
    logic mack;
    logic [WORD_W-1:0] tx_word;
    logic sda_oe_n;
    seq_state_t seq_st;
    logic [WAIT_W-1:0] wait_cnt;
    logic single;
    logic [IDX_W-1:0] idx;
    logic [CNT_W-1:0] max_cnt;
    level_array_t pend;
    level_array_t act;
    level_array_t stage;
    logic [CODE_W-1:0] wcount;
  } ctl_state_t;

  link_state_t lnk_ff;
  link_state_t nxt_lnk;
  ctl_state_t st_ff;
  ctl_state_t nxt_st;
  logic [WORD_W-1:0] rd_word;
  logic [CNT_W-1:0] rd_cnt;
  logic rd_req;

  // Link side only samples SDA at each SCL rise; the toggle marks the new bit
  always_comb begin
    nxt_lnk.bit_smp = SDA_IN;
    nxt_lnk.tgl = ~lnk_ff.tgl;
  end

  always_ff @(posedge SCL_IN or posedge RST_IN) begin
    if (RST_IN) begin
      lnk_ff <= '0;
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  assign rd_req = (st_ff.seq_st == SEQ_ISSUE);

  nv_store u_store (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .wr_en_in(NVM_WR_EN_IN),
    .wr_bank_in(NVM_WR_BANK_IN),
    .wr_idx_in(NVM_WR_IDX_IN),
    .wr_word_in(NVM_WR_WORD_IN),
    .rd_en_in(rd_req),
    .rd_bank_in(st_ff.bank_s2),
    .rd_idx_in(st_ff.idx),
    .rd_word_out(rd_word),
    .rd_cnt_out(rd_cnt)
  );

  always_comb begin
    logic start_ev;
    logic stop_ev;
    logic rise_ev;
    logic fall_ev;
    logic launch_gen;
    logic launch_sng;
    logic [LEVEL_W-1:0] val;
    logic [CNT_W-1:0] mx;
    logic [WORD_W-1:0] rdw;
    start_ev = st_ff.scl_s2 && st_ff.scl_s3 && st_ff.sda_s3 && !st_ff.sda_s2;
    stop_ev = st_ff.scl_s2 && st_ff.scl_s3 && !st_ff.sda_s3 && st_ff.sda_s2;
    rise_ev = st_ff.tgl_s2 ^ st_ff.tgl_s3;
    fall_ev = st_ff.scl_s3 && !st_ff.scl_s2;
    launch_gen = 1'b0;
    launch_sng = 1'b0;
    val = DEFAULT_LEVEL;
    mx = st_ff.max_cnt;
    rdw = 16'h0000;
    if (st_ff.ptr == PTR_WRITE_COUNT) begin
      rdw = {12'h000, st_ff.wcount};
    end else if (ptr_has_data(st_ff.ptr)) begin
      rdw = {6'h00, st_ff.pend[ptr_to_idx(st_ff.ptr)]};
    end

    nxt_st = st_ff;
    nxt_st.scl_s1 = SCL_IN;
    nxt_st.scl_s2 = st_ff.scl_s1;
    nxt_st.scl_s3 = st_ff.scl_s2;
    nxt_st.sda_s1 = SDA_IN;
    nxt_st.sda_s2 = st_ff.sda_s1;
    nxt_st.sda_s3 = st_ff.sda_s2;
    nxt_st.tgl_s1 = lnk_ff.tgl;
    nxt_st.tgl_s2 = st_ff.tgl_s1;
    nxt_st.tgl_s3 = st_ff.tgl_s2;
    nxt_st.strap_s1 = ADDR_STRAP_PIN_IN;
    nxt_st.strap_s2 = st_ff.strap_s1;
    nxt_st.bank_s1 = BANK_SELECT_PIN_IN;
    nxt_st.bank_s2 = st_ff.bank_s1;
    nxt_st.bank_s3 = st_ff.bank_s2;

    if (start_ev) begin
      nxt_st.bus_st = B_ADDR;
      nxt_st.bitcnt = 4'h0;
      nxt_st.sda_oe_n = 1'b1;
      nxt_st.cmd_ok = 1'b0;
    end else if (stop_ev) begin
      // A command counts only as a lone pointer byte closed by stop
      if (st_ff.cmd_ok && (st_ff.ptr <= PTR_ACK_LAST)) begin
        launch_gen = (st_ff.cmd == CMD_GENERAL);
        launch_sng = (st_ff.cmd == CMD_SINGLE) && ptr_has_data(st_ff.ptr);
      end
      nxt_st.bus_st = B_IDLE;
      nxt_st.sda_oe_n = 1'b1;
      nxt_st.cmd_ok = 1'b0;
    end else begin
      case (st_ff.bus_st)
        B_ADDR, B_PTR, B_WDATA: begin
          if (rise_ev && (st_ff.bitcnt != BITS_PER_BYTE)) begin
            nxt_st.shreg = {st_ff.shreg[6:0], lnk_ff.bit_smp};
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          end
          // A stop also opens with a clock rise; only a completed data bit cancels
          if (fall_ev && (st_ff.bus_st == B_WDATA)) begin
            nxt_st.cmd_ok = 1'b0;
          end
          if (fall_ev && (st_ff.bitcnt == BITS_PER_BYTE)) begin
            nxt_st.bitcnt = 4'h0;
            if (st_ff.bus_st == B_ADDR) begin
              if (st_ff.shreg[7:1] == {TARGET_ADDR_HI, st_ff.strap_s2}) begin
                nxt_st.sda_oe_n = 1'b0;
                nxt_st.bus_st = B_ADDR_ACK;
                nxt_st.rw = st_ff.shreg[0];
                nxt_st.tx_word = rdw;
                nxt_st.second = 1'b0;
              end else begin
                nxt_st.bus_st = B_IDLE;
              end
            end else if (st_ff.bus_st == B_PTR) begin
              if ((st_ff.shreg[5:0] <= PTR_ACK_LAST) ||
                  (st_ff.shreg[5:0] == PTR_WRITE_COUNT)) begin
                nxt_st.sda_oe_n = 1'b0;
                nxt_st.bus_st = B_PTR_ACK;
                nxt_st.ptr = st_ff.shreg[5:0];
                nxt_st.cmd = st_ff.shreg[7:6];
                nxt_st.cmd_ok = 1'b1;
              end else begin
                nxt_st.bus_st = B_IDLE;
              end
            end else begin
              // Data bytes are acknowledged; register writes live elsewhere
              nxt_st.sda_oe_n = 1'b0;
              nxt_st.bus_st = B_WDATA_ACK;
            end
          end
        end
        B_ADDR_ACK, B_PTR_ACK, B_WDATA_ACK: begin
          if (fall_ev) begin
            nxt_st.sda_oe_n = 1'b1;
            nxt_st.bitcnt = 4'h0;
            if ((st_ff.bus_st == B_ADDR_ACK) && st_ff.rw) begin
              nxt_st.bus_st = B_RDATA;
              nxt_st.sda_oe_n = st_ff.tx_word[15];
            end else if (st_ff.bus_st == B_ADDR_ACK) begin
              nxt_st.bus_st = B_PTR;
            end else begin
              nxt_st.bus_st = B_WDATA;
            end
          end
        end
        B_RDATA: begin
          if (rise_ev) begin
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          end
          if (fall_ev) begin
            if (st_ff.bitcnt == BITS_PER_BYTE) begin
              nxt_st.sda_oe_n = 1'b1;
              nxt_st.mack = 1'b0;
              nxt_st.bus_st = B_RACK;
            end else begin
              nxt_st.tx_word = {st_ff.tx_word[14:0], 1'b0};
              nxt_st.sda_oe_n = st_ff.tx_word[14];
            end
          end
        end
        B_RACK: begin
          if (rise_ev) begin
            nxt_st.mack = ~lnk_ff.bit_smp;
          end
          if (fall_ev) begin
            nxt_st.bitcnt = 4'h0;
            // Only one word per read; later bytes see a released line
            if (st_ff.mack && !st_ff.second) begin
              nxt_st.tx_word = {st_ff.tx_word[14:0], 1'b0};
              nxt_st.sda_oe_n = st_ff.tx_word[14];
              nxt_st.second = 1'b1;
              nxt_st.bus_st = B_RDATA;
            end else begin
              nxt_st.bus_st = B_IDLE;
            end
          end
        end
        default: begin
          nxt_st.bus_st = B_IDLE;
        end
      endcase
    end

    // A newer trigger restarts the sequence; bank change has priority
    if ((st_ff.bank_s2 != st_ff.bank_s3) || launch_gen) begin
      nxt_st.seq_st = SEQ_WAIT;
      nxt_st.single = 1'b0;
      nxt_st.wait_cnt = GEN_ACQ_CYC;
    end else if (launch_sng) begin
      nxt_st.seq_st = SEQ_WAIT;
      nxt_st.single = 1'b1;
      nxt_st.idx = ptr_to_idx(st_ff.ptr);
      nxt_st.wait_cnt = SNG_ACQ_CYC;
    end else begin
      case (st_ff.seq_st)
        SEQ_IDLE: begin
          nxt_st.seq_st = SEQ_IDLE;
        end
        SEQ_WAIT: begin
          if (st_ff.wait_cnt == '0) begin
            nxt_st.seq_st = SEQ_ISSUE;
            if (!st_ff.single) begin
              nxt_st.idx = '0;
              nxt_st.max_cnt = '0;
            end
          end else begin
            nxt_st.wait_cnt = st_ff.wait_cnt - WAIT_W'(1);
          end
        end
        SEQ_ISSUE: begin
          nxt_st.seq_st = SEQ_TAKE;
        end
        SEQ_TAKE: begin
          // Never-programmed words come up at mid-scale
          val = (rd_cnt == '0) ? DEFAULT_LEVEL : ecc_decode(rd_word);
          mx = (rd_cnt > st_ff.max_cnt) ? rd_cnt : st_ff.max_cnt;
          if (st_ff.single) begin
            nxt_st.pend[st_ff.idx] = val;
            nxt_st.act[st_ff.idx] = val;
            nxt_st.wcount = wc_code(rd_cnt);
            nxt_st.seq_st = SEQ_IDLE;
          end else begin
            nxt_st.stage[st_ff.idx] = val;
            nxt_st.max_cnt = mx;
            if (st_ff.idx == IDX_LAST) begin
              nxt_st.seq_st = SEQ_COMMIT;
            end else begin
              nxt_st.idx = st_ff.idx + 5'h01;
              nxt_st.seq_st = SEQ_ISSUE;
            end
          end
        end
        SEQ_COMMIT: begin
          // Staging makes all eighteen outputs change in one cycle
          nxt_st.pend = st_ff.stage;
          nxt_st.act = st_ff.stage;
          nxt_st.wcount = wc_code(st_ff.max_cnt);
          nxt_st.seq_st = SEQ_IDLE;
        end
        default: begin
          nxt_st.seq_st = SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_ff <= '0;
      st_ff.sda_oe_n <= 1'b1;
      st_ff.seq_st <= SEQ_WAIT;
      st_ff.wait_cnt <= GEN_ACQ_CYC;
    end else if (CE_IN) begin
      st_ff <= nxt_st;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE_N_OUT = st_ff.sda_oe_n;
  assign CHAN_LEVEL_OUT = st_ff.act;
  assign CHAN_PENDING_OUT = st_ff.pend;
  assign WRITE_COUNT_OUT = st_ff.wcount;
  assign ACQ_BUSY_OUT = (st_ff.seq_st != SEQ_IDLE);
endmodule : gamma_nvm_bank_acquire

// ==== gamma_nvm_bank_acquire_monitor.sv ====
// Port checks on serial answer, acquire timing and report update
module gamma_nvm_bank_acquire_monitor
  import gamma_nvm_pkg::*;
#(
  parameter logic [WAIT_W-1:0] GEN_ACQ_CYC = WAIT_W'(GEN_ACQ_CYCLES)
)
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic SCL_IN,
  input wire logic BANK_SELECT_PIN_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N_OUT,
  input wire level_array_t CHAN_LEVEL_OUT,
  input wire level_array_t CHAN_PENDING_OUT,
  input wire logic [CODE_W-1:0] WRITE_COUNT_OUT,
  input wire logic ACQ_BUSY_OUT
);
  int busy_cnt_ff;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= ACQ_BUSY_OUT ? busy_cnt_ff + 1 : 0;
    end
  end
  chk_pwr_busy: assert property ($fell(RST_IN) |-> ACQ_BUSY_OUT [*8])
    else $error("busy not held after reset");
  chk_level_cause: assert property ($changed(CHAN_LEVEL_OUT) |-> $past(ACQ_BUSY_OUT))
    else $error("channel level changed outside an acquire");
  chk_report_cause: assert property ($changed(WRITE_COUNT_OUT) |-> $past(ACQ_BUSY_OUT))
    else $error("report changed outside an acquire");
  chk_pend_level: assert property ($fell(ACQ_BUSY_OUT) |-> CHAN_PENDING_OUT == CHAN_LEVEL_OUT)
    else $error("pending and active levels differ after acquire");
  chk_bank_start: assert property ($changed(BANK_SELECT_PIN_IN) |-> ##[1:8] ACQ_BUSY_OUT)
    else $error("bank change did not start an acquire");
  // Bound also catches a sequencer stuck in its wait state
  chk_busy_bound: assert property (busy_cnt_ff <= int'(GEN_ACQ_CYC) + 80)
    else $error("acquire runs too long");
  chk_ack_scl_low: assert property ($changed(SDA_OE_N_OUT) |-> !SCL_IN)
    else $error("data line changed while clock high");
  chk_sda_zero: assert property (!SDA_OE_N_OUT |-> SDA_OUT == 1'h0)
    else $error("driven data not low");
  cov_ack: cover property ($fell(SDA_OE_N_OUT));
  cov_done: cover property ($fell(ACQ_BUSY_OUT));
  cov_report: cover property ($changed(WRITE_COUNT_OUT));
endmodule : gamma_nvm_bank_acquire_monitor

bind gamma_nvm_bank_acquire gamma_nvm_bank_acquire_monitor #(.GEN_ACQ_CYC(GEN_ACQ_CYC)) u_mon (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .SCL_IN(SCL_IN),
  .BANK_SELECT_PIN_IN(BANK_SELECT_PIN_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N_OUT(SDA_OE_N_OUT),
  .CHAN_LEVEL_OUT(CHAN_LEVEL_OUT), .CHAN_PENDING_OUT(CHAN_PENDING_OUT),
  .WRITE_COUNT_OUT(WRITE_COUNT_OUT), .ACQ_BUSY_OUT(ACQ_BUSY_OUT)
);

// ==== bus_master_model.sv ====
// Serial bus master driving the link clock and open-drain data
module bus_master_model (
  output logic scl_out,
  output logic sda_oe_n_out,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock stands high between frames
  initial begin
    scl_out = 1'h1;
    sda_oe_n_out = 1'h1;
  end
  task automatic bit_io(input logic b, output logic r);
    #20 sda_oe_n_out = b;
    #20 scl_out = 1'h1;
    r = sda_in;
    #40 scl_out = 1'h0;
  endtask : bit_io
  task automatic start();
    #20 sda_oe_n_out = 1'h1;
    #20 scl_out = 1'h1;
    #40 sda_oe_n_out = 1'h0;
    #40 scl_out = 1'h0;
  endtask : start
  task automatic stop();
    #20 sda_oe_n_out = 1'h0;
    #20 scl_out = 1'h1;
    #40 sda_oe_n_out = 1'h1;
    #8;
  endtask : stop
  // Sending 8'hff releases the line so the device can drive it
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, r);
    ack = !r;
  endtask : xfer
endmodule : bus_master_model

// ==== gamma_nvm_bank_acquire_tb.sv ====
// Self-checking bench for the gamma store acquire block
module gamma_nvm_bank_acquire_tb;
  import gamma_nvm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [WAIT_W-1:0] GEN = 17'h00028;
  localparam logic [WAIT_W-1:0] SNG = 17'h00008;
  localparam int SETTLE = 100; // Scaled hold of the bank pin
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic strap = 1'h0;
  logic bank = 1'h0;
  logic wr_en = 1'h0;
  logic wr_bank = 1'h0;
  logic [IDX_W-1:0] wr_idx = 5'h00;
  logic [WORD_W-1:0] wr_word = 16'h0000;
  logic scl, m_oe_n, sda_oe_n, sda, busy;
  level_array_t lvl, pend, exp_lvl;
  logic [CODE_W-1:0] wcount;
  int fail_count = 0;
  int n_tests = 0;
  assign sda = m_oe_n & sda_oe_n; // Pull-up: either side pulls low

  bus_master_model u_master (.scl_out(scl), .sda_oe_n_out(m_oe_n), .sda_in(sda));
  gamma_nvm_bank_acquire #(.GEN_ACQ_CYC(GEN), .SNG_ACQ_CYC(SNG)) u_dut (
    .MCLK_IN(mclk), .RST_IN(rst), .CE_IN(1'h1), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE_N_OUT(sda_oe_n), .ADDR_STRAP_PIN_IN(strap),
    .BANK_SELECT_PIN_IN(bank), .NVM_WR_EN_IN(wr_en), .NVM_WR_BANK_IN(wr_bank),
    .NVM_WR_IDX_IN(wr_idx), .NVM_WR_WORD_IN(wr_word), .CHAN_LEVEL_OUT(lvl),
    .CHAN_PENDING_OUT(pend), .WRITE_COUNT_OUT(wcount), .ACQ_BUSY_OUT(busy)
  );

  always #4 mclk = ~mclk;

  task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_levels(input level_array_t e);
    for (int i = 0; i < NUM_CHAN; i++) begin
      chk_val("channel level", 16'(e[i]), 16'(lvl[i]));
      chk_val("pending level", 16'(e[i]), 16'(pend[i]));
    end
  endtask : chk_levels

  task automatic prog(input logic b, input logic [4:0] i, input logic [15:0] w);
    @(posedge mclk);
    wr_en <= 1'h1;
    wr_bank <= b;
    wr_idx <= i;
    wr_word <= w;
    @(posedge mclk);
    wr_en <= 1'h0;
  endtask : prog

  task automatic i2c_wr(input logic [7:0] a, input logic [7:0] p, output logic [1:0] k);
    logic [7:0] rx;
    k = 2'h0;
    u_master.start();
    u_master.xfer(a, 1'h1, rx, k[1]);
    if (k[1]) begin
      u_master.xfer(p, 1'h1, rx, k[0]);
    end
    u_master.stop();
  endtask : i2c_wr

  task automatic i2c_rd(input logic [7:0] p, output logic [15:0] d);
    logic k;
    u_master.start();
    u_master.xfer(8'he8, 1'h1, d[7:0], k);
    u_master.xfer(p, 1'h1, d[7:0], k);
    u_master.start();
    u_master.xfer(8'he9, 1'h1, d[7:0], k);
    u_master.xfer(8'hff, 1'h0, d[15:8], k);
    u_master.xfer(8'hff, 1'h1, d[7:0], k);
    u_master.stop();
  endtask : i2c_rd

  // Counts from the trigger until the sequencer goes idle
  task automatic wait_acq(input int lo, input int hi);
    int n;
    n = 0;
    while (busy !== 1'h1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    while (busy === 1'h1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    chk_val("acquire delay", 16'h0001, 16'(n >= lo && n <= hi));
  endtask : wait_acq

  task automatic t_powerup();
    wait_acq(GEN + 30, GEN + 60);
    exp_lvl = {NUM_CHAN{DEFAULT_LEVEL}};
    chk_levels(exp_lvl);
    chk_val("report", 16'h0000, 16'(wcount));
  endtask : t_powerup

  task automatic t_general();
    logic [1:0] k;
    repeat (3) prog(1'h0, 5'h00, ecc_encode(10'h155));
    prog(1'h0, 5'h11, ecc_encode(10'h0aa) ^ 16'h0008); // One data bit flipped
    prog(1'h0, 5'h05, ecc_encode(10'h321) ^ 16'h0028); // Two data bits flipped
    i2c_wr(8'he8, 8'h85, k);
    chk_val("general acks", 16'h0003, 16'(k));
    wait_acq(GEN + 30, GEN + 70);
    exp_lvl[0] = 10'h155;
    exp_lvl[17] = 10'h0aa;
    chk_levels(exp_lvl);
    chk_val("report", 16'h0002, 16'(wcount));
  endtask : t_general

  task automatic t_read();
    logic [15:0] d;
    logic [1:0] k;
    i2c_rd(8'h3f, d);
    chk_val("report read", 16'h0002, d);
    i2c_rd(8'h00, d);
    chk_val("pending read", 16'h0155, d);
    i2c_rd(8'h14, d);
    chk_val("unused read", 16'h0000, d);
    i2c_wr(8'he8, 8'h18, k);
    chk_val("pointer refused", 16'h0002, 16'(k));
  endtask : t_read

  task automatic t_single();
    logic [1:0] k;
    prog(1'h0, 5'h02, ecc_encode(10'h3ff));
    i2c_wr(8'he8, 8'h42, k);
    wait_acq(SNG + 2, SNG + 30);
    exp_lvl[2] = 10'h3ff;
    chk_levels(exp_lvl);
    chk_val("report", 16'h0000, 16'(wcount));
  endtask : t_single

  task automatic t_addr();
    logic [1:0] k;
    @(posedge mclk);
    strap <= 1'h1;
    repeat (4) @(posedge mclk);
    i2c_wr(8'he8, 8'h3f, k);
    chk_val("low address refused", 16'h0000, 16'(k));
    i2c_wr(8'hea, 8'h3f, k);
    chk_val("high address acked", 16'h0003, 16'(k));
    @(posedge mclk);
    strap <= 1'h0;
  endtask : t_addr

  task automatic t_bank();
    logic [1:0] k;
    prog(1'h1, 5'h09, ecc_encode(10'h123));
    repeat (17) prog(1'h1, 5'h01, ecc_encode(10'h0f0));
    @(posedge mclk);
    bank <= 1'h1;
    wait_acq(GEN + 30, GEN + 70);
    exp_lvl = {NUM_CHAN{DEFAULT_LEVEL}};
    exp_lvl[9] = 10'h123;
    exp_lvl[1] = 10'h0f0;
    chk_levels(exp_lvl);
    chk_val("report", 16'h000f, 16'(wcount));
    repeat (SETTLE) @(posedge mclk);
    i2c_wr(8'he8, 8'h49, k);
    wait_acq(SNG + 2, SNG + 30);
    chk_levels(exp_lvl);
    chk_val("report", 16'h0000, 16'(wcount));
  endtask : t_bank

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    t_powerup();
    t_general();
    t_read();
    t_single();
    t_addr();
    t_bank();
    wrap_up();
  end

  // Whole run needs some 3000 cycles
  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end
endmodule : gamma_nvm_bank_acquire_tb
